//--- pkg/uvhic_map.vh
// Constants for the user variable, homing and input command block
// Contract
// - Code 11 stores user variable to NVM
// - Code 12 reloads user variable from NVM
// - Power-up reloads all user variables first
// - Code 13: 0 start, 1 stop, 2 query
// - Query returns zero idle, nonzero searching
// - Start/stop reply OK, value don't care
// - Code 15 reads port in bank 0-2
// - Digital inputs read exactly 0 or 1
// - Digital output state also readable
// - Standalone: read value goes to accumulator
// - Direct mode: accumulator left unchanged
// - Input read replies 100 with value
`ifndef UVHIC_MAP_VH
`define UVHIC_MAP_VH
`define UVHIC_OP_STORE 8'h0B
`define UVHIC_OP_RESTORE 8'h0C
`define UVHIC_OP_HOME 8'h0D
`define UVHIC_OP_READIO 8'h0F
`define UVHIC_HOME_START 8'h00
`define UVHIC_HOME_STOP 8'h01
`define UVHIC_HOME_QUERY 8'h02
`define UVHIC_BANK_USER 8'h02
`define UVHIC_BANK_DIN 8'h00
`define UVHIC_BANK_ADC 8'h01
`define UVHIC_BANK_DOUT 8'h02
`define UVHIC_ST_OK 8'h64
`define UVHIC_ST_BAD_SUM 8'h01
`define UVHIC_ST_BAD_OP 8'h02
`define UVHIC_ST_BAD_TYPE 8'h03
`define UVHIC_ST_BAD_VAL 8'h04
`define UVHIC_FRAME_LAST 4'h8
`define UVHIC_VAR_COUNT 256
`define UVHIC_VAR_LAST 8'hFF
`define UVHIC_PORT_COUNT 8
`define UVHIC_ZERO32 32'h00000000
`define UVHIC_ONE32 32'h00000001
`endif

//--- logic/uvhic_nvm.v
// Non-volatile user variable store model with one-cycle access
`timescale 1ns/1ps
`default_nettype none
`include "uvhic_map.vh"
module uvhic_nvm (
   // Clock
   input wire core_clk,
   // Access
   input wire wr_en,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   output reg [31:0] rdata
);
   // No reset: contents must survive, like real non-volatile cells
   reg [31:0] cells [0:`UVHIC_VAR_COUNT-1];
   always @(posedge core_clk) begin
      if (wr_en) begin
         cells[addr] <= wdata;
      end
      rdata <= cells[addr];
   end
endmodule // uvhic_nvm
`default_nettype wire

//--- logic/uvhic_core.v
// Command interpreter for user variable store/restore, homing and I/O reads
`timescale 1ns/1ps
`default_nettype none
`include "uvhic_map.vh"
module uvhic_core (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // Command byte stream
   input wire rx_valid,
   input wire [7:0] rx_byte,
   // Reply byte stream
   output reg tx_valid,
   output reg [7:0] tx_byte,
   input wire tx_ready,
   // Mode and addresses
   input wire standalone,
   input wire [7:0] own_addr,
   input wire [7:0] host_addr,
   // Ports outside the clock domain
   input wire [7:0] din_pins,
   input wire [7:0] dout_state,
   input wire [79:0] adc_values,
   // Homing engine
   output reg home_start,
   output reg home_stop,
   input wire home_busy,
   // Status
   output reg ready,
   output reg [31:0] accumulator,
   // Working user variable write
   input wire uv_wr,
   input wire [7:0] uv_idx,
   input wire [31:0] uv_wdata
);
   // ==============================
   // States
   localparam [2:0] ST_BOOT = 3'h0;
   localparam [2:0] ST_BOOTW = 3'h1;
   localparam [2:0] ST_RX = 3'h2;
   localparam [2:0] ST_EXEC = 3'h3;
   localparam [2:0] ST_LOAD = 3'h4;
   localparam [2:0] ST_TX = 3'h5;
   reg [2:0] state;
   reg [3:0] cnt;
   reg [7:0] frame [0:8];
   reg [7:0] sum;
   reg [7:0] boot_idx;
   reg [31:0] uvars [0:`UVHIC_VAR_COUNT-1];
   reg [7:0] rep_status;
   reg [31:0] rep_value;
   reg rep_drop;
   reg [7:0] din_s1, din_s2, dout_s1, dout_s2;
   reg [79:0] adc_s1, adc_s2;
   reg busy_s1, busy_s2;
   reg nvm_wr;
   wire [31:0] nvm_rdata;
   wire [7:0] op = frame[1];
   wire [7:0] typ = frame[2];
   // Unregistered address, so registered read data is ready on the next edge
   wire [7:0] nvm_addr = (state == ST_BOOT) ? boot_idx : typ;
   wire [7:0] bank = frame[3];
   wire [31:0] cmd_val = {frame[4], frame[5], frame[6], frame[7]};
   integer i;
   uvhic_nvm u_nvm (
      .core_clk(core_clk),
      .wr_en(nvm_wr),
      .addr(nvm_addr),
      .wdata(uvars[nvm_addr]),
      .rdata(nvm_rdata)
   );
   // ==============================
   // Helpers
   function [7:0] reply_byte;
      input [3:0] k;
      input [7:0] st;
      input [7:0] opc;
      input [31:0] v;
      begin
         case (k)
            4'h0: reply_byte = host_addr;
            4'h1: reply_byte = own_addr;
            4'h2: reply_byte = st;
            4'h3: reply_byte = opc;
            4'h4: reply_byte = v[31:24];
            4'h5: reply_byte = v[23:16];
            4'h6: reply_byte = v[15:8];
            default: reply_byte = v[7:0];
         endcase
      end
   endfunction
   // Reply checksum over the eight leading bytes
   function [7:0] reply_sum;
      input [7:0] st;
      input [7:0] opc;
      input [31:0] v;
      begin
         reply_sum = host_addr + own_addr + st + opc + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      end
   endfunction
   // ==============================
   // Synchronisers for pins
   always @(posedge core_clk) begin
      din_s1 <= din_pins;
      din_s2 <= din_s1;
      dout_s1 <= dout_state;
      dout_s2 <= dout_s1;
      adc_s1 <= adc_values;
      adc_s2 <= adc_s1;
      busy_s1 <= home_busy;
      busy_s2 <= busy_s1;
   end
   // ==============================
   // Main sequencer
   always @(posedge core_clk) begin
      if (!rstn) begin
         state <= ST_BOOT;
         cnt <= 4'h0;
         sum <= 8'h00;
         boot_idx <= 8'h00;
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
         home_start <= 1'b0;
         home_stop <= 1'b0;
         ready <= 1'b0;
         accumulator <= `UVHIC_ZERO32;
         rep_status <= 8'h00;
         rep_value <= `UVHIC_ZERO32;
         rep_drop <= 1'b0;
         nvm_wr <= 1'b0;
      end else begin
         home_start <= 1'b0;
         home_stop <= 1'b0;
         nvm_wr <= 1'b0;
         case (state)
            ST_BOOT: begin
               // Store latches cells[boot_idx] on this edge
               state <= ST_BOOTW;
            end
            ST_BOOTW: begin
               uvars[boot_idx] <= nvm_rdata;
               if (boot_idx == `UVHIC_VAR_LAST) begin
                  ready <= 1'b1;
                  state <= ST_RX;
               end else begin
                  boot_idx <= boot_idx + 8'h01;
                  state <= ST_BOOT;
               end
            end
            ST_RX: begin
               if (uv_wr) begin
                  uvars[uv_idx] <= uv_wdata;
               end
               if (rx_valid) begin
                  frame[cnt] <= rx_byte;
                  if (cnt == `UVHIC_FRAME_LAST) begin
                     cnt <= 4'h0;
                     state <= ST_EXEC;
                  end else begin
                     sum <= sum + rx_byte;
                     cnt <= cnt + 4'h1;
                  end
               end
            end
            ST_EXEC: begin
               rep_status <= `UVHIC_ST_OK;
               rep_value <= `UVHIC_ZERO32;
               rep_drop <= (frame[0] != own_addr);
               state <= ST_TX;
               if (frame[0] != own_addr) begin
                  // Another target's frame: neither acted on nor answered
                  rep_status <= `UVHIC_ST_OK;
               end else if (sum != frame[8]) begin
                  rep_status <= `UVHIC_ST_BAD_SUM;
               end else begin
                  case (op)
                     `UVHIC_OP_STORE: begin
                        // Bank 2 expected; other banks still address user vars
                        nvm_wr <= 1'b1;
                     end
                     `UVHIC_OP_RESTORE: begin
                        // Read of cells[typ] is launched on this edge
                        state <= ST_LOAD;
                     end
                     `UVHIC_OP_HOME: begin
                        case (typ)
                           `UVHIC_HOME_START: home_start <= 1'b1;
                           `UVHIC_HOME_STOP: home_stop <= 1'b1;
                           `UVHIC_HOME_QUERY:
                              rep_value <= {31'h00000000, busy_s2};
                           default: rep_status <= `UVHIC_ST_BAD_TYPE;
                        endcase
                     end
                     `UVHIC_OP_READIO: begin
                        if (typ >= `UVHIC_PORT_COUNT) begin
                           rep_status <= `UVHIC_ST_BAD_TYPE;
                        end else begin
                           case (bank)
                              `UVHIC_BANK_DIN: begin
                                 rep_value <= {31'h00000000, din_s2[typ[2:0]]};
                                 if (standalone) accumulator <=
                                    {31'h00000000, din_s2[typ[2:0]]};
                              end
                              `UVHIC_BANK_ADC: begin
                                 rep_value <= {22'h000000, adc_s2[typ[2:0]*10 +: 10]};
                                 if (standalone) accumulator <=
                                    {22'h000000, adc_s2[typ[2:0]*10 +: 10]};
                              end
                              `UVHIC_BANK_DOUT: begin
                                 rep_value <= {31'h00000000, dout_s2[typ[2:0]]};
                                 if (standalone) accumulator <=
                                    {31'h00000000, dout_s2[typ[2:0]]};
                              end
                              default: rep_status <= `UVHIC_ST_BAD_VAL;
                           endcase
                           // Direct mode leaves accumulator alone
                        end
                     end
                     default: rep_status <= `UVHIC_ST_BAD_OP;
                  endcase
               end
            end
            ST_LOAD: begin
               uvars[nvm_addr] <= nvm_rdata;
               state <= ST_TX;
            end
            ST_TX: begin
               sum <= 8'h00;
               if (rep_drop) begin
                  // Frames for other addresses get no reply
                  state <= ST_RX;
               end else if (!tx_valid || tx_ready) begin
                  if (tx_valid && cnt == `UVHIC_FRAME_LAST) begin
                     tx_valid <= 1'b0;
                     cnt <= 4'h0;
                     state <= ST_RX;
                  end else begin
                     tx_valid <= 1'b1;
                     if (tx_valid) begin
                        cnt <= cnt + 4'h1;
                     end
                     if ((tx_valid ? cnt + 4'h1 : cnt) == `UVHIC_FRAME_LAST)
                        tx_byte <= reply_sum(rep_status, op, rep_value);
                     else
                        tx_byte <= reply_byte(tx_valid ? cnt + 4'h1 : cnt,
                           rep_status, op, rep_value);
                  end
               end
            end
            default: state <= ST_BOOT;
         endcase
      end
   end
endmodule // uvhic_core
`default_nettype wire

//--- tb/uvhic_core_monitor.sv
// Port assertions for the command block
`timescale 1ns/1ps
`default_nettype none
module uvhic_core_monitor (
   // Watched ports
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic standalone,
   input wire logic home_start,
   input wire logic home_stop,
   input wire logic ready,
   input wire logic [31:0] accumulator
);
   // ==========
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_stall;
      tx_valid && !tx_ready;
   endsequence
   sequence s_held;
      tx_valid && $stable(tx_byte);
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !tx_valid && !ready)
      else $error("outputs active after reset");
   a_restore_first: assert property ($rose(rstn) |-> !ready [*8])
      else $error("ready too early");
   a_ready_held: assert property (ready |=> ready)
      else $error("ready dropped");
   a_no_early_reply: assert property (!ready |-> !tx_valid)
      else $error("reply before restore");
   a_tx_hold: assert property (s_stall |=> s_held)
      else $error("reply byte changed while stalled");
   a_start_pulse: assert property (home_start |=> !home_start)
      else $error("start pulse too long");
   a_stop_pulse: assert property (home_stop |=> !home_stop)
      else $error("stop pulse too long");
   a_start_stop_apart: assert property (!(home_start && home_stop))
      else $error("start and stop together");
   a_acc_direct: assert property (!standalone |=> $stable(accumulator))
      else $error("accumulator moved in direct mode");
endmodule // uvhic_core_monitor
`default_nettype wire

//--- tb/uvhic_host_model.sv
// Host model sending command frames and taking replies
`timescale 1ns/1ps
`default_nettype none
module uvhic_host_model (
   // Link
   input wire logic core_clk,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   logic [7:0] rep [0:8];
   logic slow = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'hA5;
      tx_ready = 1'b0;
   end
   // Slow mode stalls every other cycle so held bytes get exercised
   task automatic xfer(input logic [7:0] a, op, ty, bk, output int n);
      logic [7:0] f [0:9];
      f = '{a, op, ty, bk, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      f[8] = a + op + ty + bk;
      n = 0;
      for (int i = 0; i < 9; i++) begin
         @(posedge core_clk) #1;
         rx_valid = 1'b1;
         rx_byte = f[i];
         @(posedge core_clk) #1;
         rx_valid = 1'b0;
         rx_byte = ~f[i];
      end
      for (int c = 0; c < 60 && n < 9; c++) begin
         @(posedge core_clk);
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            rep[n] = tx_byte;
            n++;
         end
         #1 tx_ready = (n < 9) && !(slow && tx_ready);
      end
   endtask
endmodule // uvhic_host_model
`default_nettype wire

//--- tb/tb_uvhic_core.sv
// Testbench for the command block
`timescale 1ns/1ps
`default_nettype none
module tb_uvhic_core;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic rx_valid, tx_valid, tx_ready, home_start, home_stop, ready;
   logic [7:0] rx_byte, tx_byte;
   logic standalone = 1'b0;
   logic [7:0] din_pins = 8'h08;
   logic [7:0] dout_state = 8'h40;
   logic [79:0] adc_values = 80'h4B800;
   logic home_busy = 1'b0;
   logic uv_wr = 1'b0;
   logic [31:0] accumulator, val;
   int n_fail = 0, checks = 0, cyc = 0, n, starts = 0, stops = 0;
   // Last direct read is non-zero so a leaking accumulator shows
   logic [7:0] bk [5] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h01};
   logic [7:0] pt [5] = '{8'h03, 8'h02, 8'h06, 8'h00, 8'h01};
   logic [31:0] ex [5] = '{32'h00000001, 32'h00000000, 32'h00000001, 32'h00000000, 32'h0000012E};
   uvhic_core uvhic_core_inst (.core_clk(core_clk), .rstn(rstn), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
      .standalone(standalone), .own_addr(8'h01), .host_addr(8'h02), .din_pins(din_pins),
      .dout_state(dout_state), .adc_values(adc_values), .home_start(home_start),
      .home_stop(home_stop), .home_busy(home_busy), .ready(ready),
      .accumulator(accumulator), .uv_wr(uv_wr), .uv_idx(8'h2A), .uv_wdata(32'h5A5A0042));
   uvhic_host_model uvhic_host_model_inst (.core_clk(core_clk), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
   always #20 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (home_start === 1'b1) starts++;
      if (home_stop === 1'b1) stops++;
      if (cyc == 6000) begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, ty, b, input logic [31:0] v, input logic vc);
      logic [7:0] s;
      s = 8'h00;
      uvhic_host_model_inst.xfer(8'h01, op, ty, b, n);
      for (int i = 0; i < 8; i++) s += uvhic_host_model_inst.rep[i];
      val = {uvhic_host_model_inst.rep[4], uvhic_host_model_inst.rep[5],
         uvhic_host_model_inst.rep[6], uvhic_host_model_inst.rep[7]};
      chk(n, 9);
      chk({uvhic_host_model_inst.rep[0], uvhic_host_model_inst.rep[1]}, 16'h0201);
      chk({uvhic_host_model_inst.rep[2], uvhic_host_model_inst.rep[3]}, {8'h64, op});
      chk(uvhic_host_model_inst.rep[8], s);
      if (vc) chk(val, v);
   endtask
   task automatic t_uvar;
      @(posedge core_clk) #1 uv_wr = 1'b1;
      @(posedge core_clk) #1 uv_wr = 1'b0;
      cmd(8'h0B, 8'h2A, 8'h02, 0, 0);
      uvhic_host_model_inst.slow = 1'b1;
      cmd(8'h0C, 8'h2A, 8'h02, 0, 0);
      uvhic_host_model_inst.slow = 1'b0;
      $display("user variable test done");
   endtask
   task automatic t_home;
      cmd(8'h0D, 8'h00, 8'h00, 0, 0);
      chk(starts, 1);
      cmd(8'h0D, 8'h02, 8'h00, 0, 1);
      home_busy = 1'b1;
      cmd(8'h0D, 8'h02, 8'h00, 0, 0);
      chk(val != 0, 1);
      cmd(8'h0D, 8'h01, 8'h00, 0, 0);
      chk(stops, 1);
      home_busy = 1'b0;
      $display("homing test done");
   endtask
   task automatic t_err;
      // Frame for another target: no reply and no start pulse
      uvhic_host_model_inst.xfer(8'h05, 8'h0D, 8'h00, 8'h00, n);
      chk(n, 0);
      chk(starts, 1);
      uvhic_host_model_inst.xfer(8'h01, 8'h0F, 8'h08, 8'h00, n);
      chk(uvhic_host_model_inst.rep[2], 8'h03);
      uvhic_host_model_inst.xfer(8'h01, 8'h0F, 8'h00, 8'h03, n);
      chk(uvhic_host_model_inst.rep[2], 8'h04);
      $display("error test done");
   endtask
   task automatic t_gio;
      for (int i = 0; i < 5; i++) cmd(8'h0F, pt[i], bk[i], ex[i], 1);
      chk(accumulator, 0);
      standalone = 1'b1;
      cmd(8'h0F, 8'h01, 8'h01, 302, 1);
      chk(accumulator, 302);
      $display("input read test done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      #1 rstn = 1'b1;
      for (int i = 0; i < 600 && ready !== 1'b1; i++) @(posedge core_clk);
      chk(ready, 1);
      t_uvar();
      t_home();
      t_err();
      t_gio();
      results();
   end
endmodule // tb_uvhic_core
bind uvhic_core uvhic_core_monitor uvhic_core_monitor_inst (.core_clk(core_clk), .rstn(rstn),
   .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .standalone(standalone),
   .home_start(home_start), .home_stop(home_stop), .ready(ready), .accumulator(accumulator));
`default_nettype wire
